/* File: ppl_position_latch.sv */
/*
 * Position probe latch: four measured-value holders loaded on probe edges
 * during an active measurement cycle, with recorded flags, interrupts and an
 * AXI4-Lite register slave. Assumes probes are asynchronous pins and the
 * position inputs are already on aclk.
 */
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Probe-one falling edge in an active cycle latches position into holder 1F.
// RULE_02 - Probe-two rising edge in an active cycle latches position into holder 2R.
// RULE_03 - Probe-two falling edge in an active cycle latches position into holder 2F.
// RULE_04 - Latched value is the external encoder position if present, else motor position.
// RULE_05 - Probe enables are honoured only while the cycle command is active.
// RULE_06 - Master re-arms a repeat measurement by toggling the enable low then high.
// RULE_07 - Only bit 0 of enable and recorded-flag words is meaningful; the code packs the four recorded flags into bits 3:0 of one status word.
// RULE_08 - Enables may arrive as mapped real-time control bits.
// RULE_09 - Recorded flags are available as mapped real-time status bits.
// RULE_10 - Probe-one rising flag sets only with cycle active, enable one, rising edge.
// RULE_11 - Probe-one rising holder loads in the same step its flag sets.
// RULE_12 - Probe-one rising flag clears when cycle command or enable drops.
// RULE_13 - Clearing the cycle command clears the whole measured-value status word.
// RULE_14 - Master may measure repeatedly in one cycle and clears it when done.
// RULE_15 - Probe-one falling flag follows the rising flag's set and clear conditions.
// RULE_16 - Probes are synchronised; capture and flag share the edge's clock cycle.
module ppl_position_latch (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Probe pins and position feedback.
	input  wire logic        probe1_pin,
	input  wire logic        probe2_pin,
	input  wire logic [31:0] motor_pos,
	input  wire logic [31:0] ext_pos,
	// Real-time mapped bits and interrupt.
	input  wire logic        rt_en1,
	input  wire logic        rt_en2,
	input  wire logic        rt_map_en,
	output logic [3:0]       rt_status,
	output logic             irq
);

	ppl_pkg::ppl_edge_s  edge1;
	ppl_pkg::ppl_edge_s  edge2;
	ppl_pkg::ppl_ctrl_s  ctl;
	logic [1:0]          ctrl_reg, ctrl_next;
	logic                en1_reg, en1_next, en2_reg, en2_next;
	logic [3:0]          rec_reg, rec_next;
	logic [3:0]          irq_st_reg, irq_st_next, irq_msk_reg, irq_msk_next;
	logic [3:0]          cap_evt;
	logic [31:0]         cap_pos;
	logic [31:0]         hold_rdata;
	logic                aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0]          awaddr_reg, awaddr_next;
	logic [31:0]         wdata_reg, wdata_next;
	logic                bvalid_reg, bvalid_next;
	logic [1:0]          bresp_reg, bresp_next;
	logic                rvalid_reg, rvalid_next;
	logic [1:0]          rresp_reg, rresp_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic                wr_go, rd_go;
	logic [1:0]          hold_sel;

	// Probe conditioners. [RULE_16]
	ppl_probe_sync u_sync1 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.probe_pin (probe1_pin),
		.edges     (edge1)
	);
	ppl_probe_sync u_sync2 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.probe_pin (probe2_pin),
		.edges     (edge2)
	);

	// Effective control; mapped real-time bits replace the register enables. [RULE_08]
	always_comb begin
		ctl.cycle   = ctrl_reg[ppl_pkg::CTRL_CYCLE_BIT];
		ctl.ext_enc = ctrl_reg[ppl_pkg::CTRL_EXT_BIT];
		ctl.en1     = rt_map_en ? rt_en1 : en1_reg;
		ctl.en2     = rt_map_en ? rt_en2 : en2_reg;
	end

	// Captured source: external encoder when fitted, else motor encoder. [RULE_04]
	assign cap_pos = ctl.ext_enc ? ext_pos : motor_pos;

	// Capture strobes: enables are looked at only during a cycle. [RULE_05] [RULE_10] [RULE_15]
	// An armed edge fires only while its flag is clear, so the master must
	// drop and raise the enable to measure the same edge again. [RULE_06]
	always_comb begin
		cap_evt = ppl_pkg::ZERO_NIB;
		if (ctl.cycle) begin
			cap_evt[ppl_pkg::ST_P1R] = ctl.en1 & edge1.rise & ~rec_reg[ppl_pkg::ST_P1R];
			cap_evt[ppl_pkg::ST_P1F] = ctl.en1 & edge1.fall & ~rec_reg[ppl_pkg::ST_P1F];
			cap_evt[ppl_pkg::ST_P2R] = ctl.en2 & edge2.rise & ~rec_reg[ppl_pkg::ST_P2R];
			cap_evt[ppl_pkg::ST_P2F] = ctl.en2 & edge2.fall & ~rec_reg[ppl_pkg::ST_P2F];
		end
	end

	// Recorded flags: cleared by cycle or enable dropping; a capture sets them. [RULE_12] [RULE_13]
	always_comb begin
		rec_next = rec_reg | cap_evt;
		if (!ctl.cycle) begin
			rec_next = ppl_pkg::ZERO_NIB;
		end else begin
			if (!ctl.en1) begin
				rec_next[ppl_pkg::ST_P1R] = 1'b0;
				rec_next[ppl_pkg::ST_P1F] = 1'b0;
			end
			if (!ctl.en2) begin
				rec_next[ppl_pkg::ST_P2R] = 1'b0;
				rec_next[ppl_pkg::ST_P2F] = 1'b0;
			end
		end
	end

	// Holders live in the small memory; writes share the capture cycle. [RULE_11] [RULE_01] [RULE_02] [RULE_03]
	ppl_hold_mem u_hold (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (cap_evt),
		.wr_data (cap_pos),
		.rd_sel  (hold_sel),
		.rd_data (hold_rdata)
	);

	// Flags reach the master as mapped real-time status bits. [RULE_09]
	assign rt_status = rec_reg;

	// Interrupt status sets on capture, clears by writing one; set wins.
	always_comb begin
		irq_st_next = irq_st_reg;
		if (wr_go && ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_IRQ_ST)) begin
			irq_st_next = irq_st_reg & ~wdata_reg[3:0];
		end
		irq_st_next = irq_st_next | cap_evt;
	end
	assign irq = |(irq_st_reg & irq_msk_reg);

	// Write channel: address and data are taken in either order.
	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
	assign wr_go         = aw_held_reg & w_held_reg & ~bvalid_reg;

	// Write path and control registers; only bit 0 of enable words counts. [RULE_07]
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		ctrl_next    = ctrl_reg;
		en1_next     = en1_reg;
		en2_next     = en2_reg;
		irq_msk_next = irq_msk_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata;
		end
		if (wr_go) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = ppl_pkg::RESP_OKAY;
			if (ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_CTRL)) begin
				ctrl_next = wdata_reg[1:0];
			end else if (ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_EN1)) begin
				en1_next = wdata_reg[ppl_pkg::ENABLE_BIT];
			end else if (ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_EN2)) begin
				en2_next = wdata_reg[ppl_pkg::ENABLE_BIT];
			end else if (ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_IRQ_MSK)) begin
				irq_msk_next = wdata_reg[3:0];
			end else if (!ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_IRQ_ST)
				&& !ppl_pkg::ppl_hit(awaddr_reg, ppl_pkg::ADDR_STATUS)
				&& (awaddr_reg < ppl_pkg::ADDR_VAL1P || awaddr_reg > ppl_pkg::ADDR_VAL2N)) begin
				bresp_next = ppl_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// Read channel: the holder is picked from the incoming address, so its
	// registered word is already settled when the reply is built a cycle later.
	logic rd_pend_reg, rd_pend_next;
	logic [7:0] araddr_reg, araddr_next;
	assign s_axi_arready = ~rvalid_reg & ~rd_pend_reg;
	assign rd_go         = s_axi_arvalid & s_axi_arready;
	assign hold_sel      = 2'((araddr_next - ppl_pkg::ADDR_VAL1P) >> 2);

	// Read decode; unused bits of flag words read zero. [RULE_07]
	always_comb begin
		rd_pend_next = rd_pend_reg;
		araddr_next  = araddr_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (rd_go) begin
			rd_pend_next = 1'b1;
			araddr_next  = s_axi_araddr;
		end
		if (rd_pend_reg) begin
			rd_pend_next = 1'b0;
			rvalid_next  = 1'b1;
			rresp_next   = ppl_pkg::RESP_OKAY;
			rdata_next   = ppl_pkg::ZERO_WORD;
			if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_CTRL)) begin
				rdata_next[1:0] = ctrl_reg;
			end else if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_EN1)) begin
				rdata_next[ppl_pkg::ENABLE_BIT] = en1_reg;
			end else if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_EN2)) begin
				rdata_next[ppl_pkg::ENABLE_BIT] = en2_reg;
			end else if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_STATUS)) begin
				rdata_next[3:0] = rec_reg;
			end else if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_IRQ_ST)) begin
				rdata_next[3:0] = irq_st_reg;
			end else if (ppl_pkg::ppl_hit(araddr_reg, ppl_pkg::ADDR_IRQ_MSK)) begin
				rdata_next[3:0] = irq_msk_reg;
			end else if (araddr_reg >= ppl_pkg::ADDR_VAL1P
				&& araddr_reg[7:2] <= ppl_pkg::ADDR_VAL2N[7:2]) begin
				rdata_next = hold_rdata;
			end else begin
				rresp_next = ppl_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// All state registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg    <= 2'h0;
			en1_reg     <= 1'b0;
			en2_reg     <= 1'b0;
			rec_reg     <= ppl_pkg::ZERO_NIB;
			irq_st_reg  <= ppl_pkg::ZERO_NIB;
			irq_msk_reg <= ppl_pkg::ZERO_NIB;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= ppl_pkg::ZERO_WORD;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= ppl_pkg::RESP_OKAY;
			rd_pend_reg <= 1'b0;
			araddr_reg  <= 8'h00;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= ppl_pkg::RESP_OKAY;
			rdata_reg   <= ppl_pkg::ZERO_WORD;
		end else begin
			ctrl_reg    <= ctrl_next;
			en1_reg     <= en1_next;
			en2_reg     <= en2_next;
			rec_reg     <= rec_next;
			irq_st_reg  <= irq_st_next;
			irq_msk_reg <= irq_msk_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rd_pend_reg <= rd_pend_next;
			araddr_reg  <= araddr_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Checks on the capture and flag logic.
	a_p1r_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
		$rose(rec_reg[ppl_pkg::ST_P1R]) |-> $past(ctl.cycle & ctl.en1 & edge1.rise))
		else $error("Probe one rising flag set without cause.");
	a_p1f_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
		$rose(rec_reg[ppl_pkg::ST_P1F]) |-> $past(ctl.cycle & ctl.en1 & edge1.fall))
		else $error("Probe one falling flag set without cause.");
	a_p1r_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
		cap_evt[ppl_pkg::ST_P1R] |=> rec_reg[ppl_pkg::ST_P1R])
		else $error("Probe one rising capture did not set its flag.");
	a_p1f_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
		(ctl.cycle & ctl.en1 & edge1.fall & ~rec_reg[ppl_pkg::ST_P1F]) |=>
		u_hold.mem_reg[ppl_pkg::ST_P1F] == $past(cap_pos))
		else $error("Probe one falling edge missed.");
	a_p2r_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
		(ctl.cycle & ctl.en2 & edge2.rise & ~rec_reg[ppl_pkg::ST_P2R]) |=> rec_reg[ppl_pkg::ST_P2R])
		else $error("Probe two rising edge missed.");
	a_p2f_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
		(ctl.cycle & ctl.en2 & edge2.fall & ~rec_reg[ppl_pkg::ST_P2F]) |=> rec_reg[ppl_pkg::ST_P2F])
		else $error("Probe two falling edge missed.");
	a_cycle_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
		!ctl.cycle |=> rec_reg == ppl_pkg::ZERO_NIB)
		else $error("Status not cleared with cycle inactive.");
	a_enable_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
		(ctl.cycle & !ctl.en1) |=> !rec_reg[ppl_pkg::ST_P1R] && !rec_reg[ppl_pkg::ST_P1F])
		else $error("Probe one flags not cleared on enable low.");
	a_no_cycle_cap: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
		!ctl.cycle |-> cap_evt == ppl_pkg::ZERO_NIB)
		else $error("Capture outside measurement cycle.");
	a_pos_source: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
		(cap_evt[ppl_pkg::ST_P2R] & ctl.ext_enc) |=>
		u_hold.mem_reg[ppl_pkg::ST_P2R] == $past(ext_pos))
		else $error("Wrong position source.");
	c_p1r_capture: cover property (@(posedge aclk) disable iff (!aresetn) cap_evt[ppl_pkg::ST_P1R]);
	c_p2f_capture: cover property (@(posedge aclk) disable iff (!aresetn) cap_evt[ppl_pkg::ST_P2F]);
	c_cycle_end: cover property (@(posedge aclk) disable iff (!aresetn)
		rec_reg != ppl_pkg::ZERO_NIB ##1 !ctl.cycle);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule

/* File: ppl_pkg.sv */
/*
 * Package for the position probe latch: register offsets, field positions,
 * reset values and the carrier structs shared by the latch and its helpers.
 * Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
 */
package ppl_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_EN1     = 8'h04;
	localparam logic [7:0] ADDR_EN2     = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;
	localparam logic [7:0] ADDR_VAL1P   = 8'h18;
	localparam logic [7:0] ADDR_VAL1N   = 8'h1C;
	localparam logic [7:0] ADDR_VAL2P   = 8'h20;
	localparam logic [7:0] ADDR_VAL2N   = 8'h24;

	// Control register field positions.
	localparam int CTRL_CYCLE_BIT = 0;
	localparam int CTRL_EXT_BIT   = 1;
	localparam int ENABLE_BIT     = 0;

	// Status bit positions: probe one rising, falling, probe two rising, falling.
	localparam int ST_P1R = 0;
	localparam int ST_P1F = 1;
	localparam int ST_P2R = 2;
	localparam int ST_P2F = 3;
	localparam int NUM_CAP = 4;

	// Widths and reset values.
	localparam int POS_W = 32;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [3:0]  ZERO_NIB  = 4'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Synchroniser stages and the two probe lines.
	localparam int SYNC_STAGES = 3;
	localparam int NUM_PROBES  = 2;

	// Edge events of one probe.
	typedef struct packed {
		logic rise;
		logic fall;
	} ppl_edge_s;

	// Cycle control as seen by the latch logic.
	typedef struct packed {
		logic cycle;
		logic ext_enc;
		logic en1;
		logic en2;
	} ppl_ctrl_s;

	// Returns one when the address selects the given register.
	function automatic logic ppl_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		return addr[7:2] == reg_addr[7:2];
	endfunction

endpackage

/* File: ppl_probe_sync.sv */
/*
 * Probe input conditioner: three-stage synchroniser and edge detector.
 * Assumes the probe pin is asynchronous to aclk; an edge counts once the
 * second and third stages agree on a new level.
 */
`timescale 1ns/10ps
module ppl_probe_sync (
	// Clock and reset.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Probe pin and detected edges.
	input  wire logic              probe_pin,
	output ppl_pkg::ppl_edge_s     edges
);

	logic [ppl_pkg::SYNC_STAGES-1:0] sync_reg;
	logic [ppl_pkg::SYNC_STAGES-1:0] sync_next;
	logic                            level_reg;
	logic                            level_next;

	// Shift the pin in; the level follows once stages two and three agree.
	always_comb begin
		sync_next  = {sync_reg[ppl_pkg::SYNC_STAGES-2:0], probe_pin};
		level_next = level_reg;
		if (sync_reg[1] == sync_reg[2]) begin
			level_next = sync_reg[2];
		end
	end

	// Registers only; the first stage feeds nothing but the second.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_reg  <= '0;
			level_reg <= 1'b0;
		end else begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
		end
	end

	// Edge pulses last one cycle, in the cycle the level is about to change. [RULE_16]
	assign edges.rise = level_next & ~level_reg;
	assign edges.fall = ~level_next & level_reg;

endmodule

/* File: ppl_hold_mem.sv */
/*
 * Measured-value holders: four position words, each written by its own
 * capture strobe, read through a registered port.
 * Assumes strobes and data are on aclk.
 */
`timescale 1ns/10ps
module ppl_hold_mem (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Capture writes.
	input  wire logic [3:0]  wr_en,
	input  wire logic [31:0] wr_data,
	// Registered read.
	input  wire logic [1:0]  rd_sel,
	output logic [31:0]      rd_data
);

	logic [31:0] mem_reg [ppl_pkg::NUM_CAP];
	logic [31:0] mem_next [ppl_pkg::NUM_CAP];
	logic [31:0] rd_reg;

	// Each holder loads independently so simultaneous edges all land.
	always_comb begin
		for (int i = 0; i < ppl_pkg::NUM_CAP; i++) begin
			mem_next[i] = wr_en[i] ? wr_data : mem_reg[i];
		end
	end

	// Holders and read register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < ppl_pkg::NUM_CAP; i++) begin
				mem_reg[i] <= ppl_pkg::ZERO_WORD;
			end
			rd_reg <= ppl_pkg::ZERO_WORD;
		end else begin
			for (int i = 0; i < ppl_pkg::NUM_CAP; i++) begin
				mem_reg[i] <= mem_next[i];
			end
			rd_reg <= mem_reg[rd_sel];
		end
	end
	assign rd_data = rd_reg;

endmodule

/* File: ppl_master_model.sv */
/*
 * Behavioural model of the cyclic fieldbus master that drives the mapped
 * real-time control bits and samples the mapped real-time status bits.
 * Assumes the bench issues its requests on aclk; one cycle of bus latency.
 */
`timescale 1ns/10ps
module ppl_master_model (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Requests from the bench.
	input  wire logic       map_req,
	input  wire logic       en1_req,
	input  wire logic       en2_req,
	// Cyclic control bits out, status bits back.
	output logic            rt_map_en,
	output logic            rt_en1,
	output logic            rt_en2,
	input  wire logic [3:0] rt_status,
	output logic [3:0]      status_seen
);
	// One cycle of telegram delay; a re-arm is only a low cycle then a high one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rt_map_en   <= 1'b0;
			rt_en1      <= 1'b0;
			rt_en2      <= 1'b0;
			status_seen <= 4'h0;
		end else begin
			rt_map_en   <= map_req;
			rt_en1      <= en1_req;
			rt_en2      <= en2_req;
			status_seen <= rt_status;
		end
	end
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for the position probe latch: AXI4-Lite master tasks,
 * probe pin stimulus and the fieldbus master model.
 * Assumes a 50 MHz aclk and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module tb;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd, mpos = 32'h0000_0000, epos = 32'h0000_0000;
	logic [1:0] bresp, rresp, rs, bs;
	logic awready, wready, bvalid, arready, rvalid, irq, p1 = 1'b0, p2 = 1'b0;
	logic map_req = 1'b0, en1_req = 1'b0, en2_req = 1'b0, rt_en1, rt_en2, rt_map_en;
	logic [3:0] rt_status, seen;
	int fail_count = 0, num_checks = 0;

	always #10 aclk = ~aclk;

	ppl_position_latch i_ppl_position_latch (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .probe1_pin(p1), .probe2_pin(p2),
		.motor_pos(mpos), .ext_pos(epos), .rt_en1(rt_en1), .rt_en2(rt_en2),
		.rt_map_en(rt_map_en), .rt_status(rt_status), .irq(irq));

	ppl_master_model i_ppl_master_model (.aclk(aclk), .aresetn(aresetn),
		.map_req(map_req), .en1_req(en1_req), .en2_req(en2_req), .rt_map_en(rt_map_en),
		.rt_en1(rt_en1), .rt_en2(rt_en2), .rt_status(rt_status), .status_seen(seen));

	// Prints the verdict and ends the run; every hang limit also lands here.
	task automatic stop_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// Write: address and data offered together, each dropped when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bs = bresp;
		bready <= 1'b0;
		if (n >= 50) begin
			chk("write timeout", 32'h0000_0000, 32'h0000_0001);
			stop_test();
		end
		@(posedge aclk);
	endtask

	task automatic rdw(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n >= 50) begin
			chk("read timeout", 32'h0000_0000, 32'h0000_0001);
			stop_test();
		end
		@(posedge aclk);
	endtask

	// Reads a register and compares it with an OKAY response.
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		rdw(a);
		chk(what, exp, rd);
		chk("rresp", {30'h0, ppl_pkg::RESP_OKAY}, {30'h0, rs});
	endtask

	// Drives a probe pin and waits a bounded time for its recorded flag.
	task automatic cap(input int p, input logic lvl, input int b);
		int n;
		if (p == 1) p1 <= lvl;
		else p2 <= lvl;
		for (n = 0; n < 12 && rt_status[b] !== 1'b1; n++) @(posedge aclk);
		if (n >= 12) begin
			chk("flag timeout", 32'h0000_0000, 32'h0000_0001);
			stop_test();
		end
	endtask

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge aclk);
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	// Main sequence.
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("status", ppl_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("rt_status", 32'h0000_0000, {28'h0, rt_status});
		irq_is(1'b0);
		rdw(8'h3C);
		chk("unmapped resp", {30'h0, ppl_pkg::RESP_SLVERR}, {30'h0, rs});
		chk("unmapped data", 32'h0000_0000, rd);
		wr(8'h3C, 32'h0000_0001);
		chk("unmapped bresp", {30'h0, ppl_pkg::RESP_SLVERR}, {30'h0, bs});
		wr(ppl_pkg::ADDR_IRQ_MSK, 32'h0000_000F);
		chk("bresp", {30'h0, ppl_pkg::RESP_OKAY}, {30'h0, bs});
		wr(ppl_pkg::ADDR_CTRL, 32'h0000_0001);
		wr(ppl_pkg::ADDR_EN1, 32'h0000_0001);
		wr(ppl_pkg::ADDR_EN2, 32'h0000_0001);
		mpos <= 32'h0000_1111;
		epos <= 32'h0000_2222;
		cap(1, 1'b1, ppl_pkg::ST_P1R);
		rchk("hold 1R", ppl_pkg::ADDR_VAL1P, 32'h0000_1111);
		irq_is(1'b1);
		wr(ppl_pkg::ADDR_IRQ_ST, 32'h0000_000F);
		irq_is(1'b0);
		mpos <= 32'h0000_3333;
		cap(1, 1'b0, ppl_pkg::ST_P1F);
		rchk("hold 1F", ppl_pkg::ADDR_VAL1N, 32'h0000_3333);
		// A second rising edge without re-arming must leave the holder alone.
		mpos <= 32'h0000_4444;
		p1 <= 1'b1;
		repeat (10) @(posedge aclk);
		rchk("hold 1R again", ppl_pkg::ADDR_VAL1P, 32'h0000_1111);
		wr(ppl_pkg::ADDR_CTRL, 32'h0000_0003);
		cap(2, 1'b1, ppl_pkg::ST_P2R);
		rchk("hold 2R", ppl_pkg::ADDR_VAL2P, 32'h0000_2222);
		epos <= 32'h0000_5555;
		cap(2, 1'b0, ppl_pkg::ST_P2F);
		rchk("hold 2F", ppl_pkg::ADDR_VAL2N, 32'h0000_5555);
		rchk("status all", ppl_pkg::ADDR_STATUS, 32'h0000_000F);
		chk("master status", 32'h0000_000F, {28'h0, seen});
		wr(ppl_pkg::ADDR_EN1, 32'hFFFF_FFFE);
		rchk("status en1 off", ppl_pkg::ADDR_STATUS, 32'h0000_000C);
		// Hand the enables to the mapped control bits and re-arm probe one.
		en1_req <= 1'b1;
		en2_req <= 1'b1;
		map_req <= 1'b1;
		repeat (2) @(posedge aclk);
		epos <= 32'h0000_6666;
		cap(1, 1'b0, ppl_pkg::ST_P1F);
		rchk("hold 1F mapped", ppl_pkg::ADDR_VAL1N, 32'h0000_6666);
		en1_req <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("mapped en1 off", 32'h0000_000C, {28'h0, rt_status});
		en1_req <= 1'b1;
		wr(ppl_pkg::ADDR_CTRL, 32'h0000_0002);
		rchk("status cycle off", ppl_pkg::ADDR_STATUS, 32'h0000_0000);
		p2 <= 1'b1;
		repeat (10) @(posedge aclk);
		rchk("hold 2R idle", ppl_pkg::ADDR_VAL2P, 32'h0000_2222);
		wr(ppl_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
		irq_is(1'b0);
		rchk("irq status", ppl_pkg::ADDR_IRQ_ST, 32'h0000_000E);
		wr(ppl_pkg::ADDR_IRQ_MSK, 32'h0000_000F);
		irq_is(1'b1);
		wr(ppl_pkg::ADDR_IRQ_ST, 32'h0000_000E);
		irq_is(1'b0);
		stop_test();
	end
endmodule
